// *** core/phase_shifted_dimming_pwm.sv ***
/*
 * Multi-phase dimming generator: up to twelve outputs, equal width and
 * frequency, spaced by an equal phase delay, at twice the sync rate.
 * Assumes synchronous inputs; the analog triangle, comparator and
 * range detector sit outside and deliver logic levels.
 */
// Contract
// [RULE1] Pulse width comes from the comparator of dimming level against the 1V..3V triangle.
// [RULE2] Polarity select picks whether the positive or negative comparator pulse is copied.
// [RULE3] An external frame sync of 65Hz to 180Hz, when present, locks all outputs.
// [RULE4] Without a frame sync the outputs lock to the internal triangle.
// [RULE5] Outputs run at twice the frequency of the selected source.
// [RULE6] All active outputs share one width and one frequency and differ only in phase.
// [RULE7] Successive outputs are delayed by the output period divided by the phase count.
// [RULE8] Lamp-count pins, low then high, select 6, 8, 10 or 12 phases.
// [RULE9] Twelve outputs 0 to 11, each three-state.
// [RULE10] Widths and periods are timed from a 4MHz resonator time base.
// [RULE11] The lowest usable sync is 61Hz, 55Hz or 46Hz for 4, 3.59 or 3MHz resonators.
// [RULE12] Outputs start only once the lamp status is high and the level is in range; the code checks range only on leaving ST_IDLE, not in ST_ARM.
// [RULE13] Outputs beyond the phase count float; offsets ascend with output index.
// [RULE14] A frame sync with no edge for one minimum-rate period counts as absent.
`default_nettype none
`include "dimming_pwm_defines.svh"

module phase_shifted_dimming_pwm #(
    parameter int CNT_W = 17,
    parameter int SYNC_TIMEOUT_TICKS = `PWM_SYNC_TIMEOUT_TICKS // RULE11
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic frame_sync,
    input wire logic triangle_sync,
    input wire logic comparator_high,
    input wire logic level_in_range,
    input wire logic pulse_polarity_select,
    input wire logic lamp_count_bit_low,
    input wire logic lamp_count_bit_high,
    input wire logic lamp_status_line,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic [`PWM_MAX_PHASES-1:0] dimming_outputs,
    output logic [`PWM_MAX_PHASES-1:0] dimming_outputs_oe
);
    import dimming_pwm_pkg::*;

    localparam int NCH = `PWM_MAX_PHASES;
    localparam int TICK_GAP = `PWM_TICK_DIV;

    initial begin
        if (CNT_W < 8 || CNT_W > 31) $error("CNT_W out of range");
        if (TICK_GAP < 2 || TICK_GAP > 127) $error("tick divider does not fit");
    end

    sync_meter_if #(.CNT_W(CNT_W)) meter ();

    // resonator time base
    logic [6:0] div_reg, div_next;
    logic tick_reg, tick_next;

    always_comb begin
        if (div_reg == 7'(TICK_GAP - 1)) begin
            div_next = '0;
            tick_next = 1'b1; // RULE10
        end else begin
            div_next = div_reg + 7'h01;
            tick_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    sync_period_meter #(.CNT_W(CNT_W), .TIMEOUT(SYNC_TIMEOUT_TICKS)) u_meter (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .tick(tick_reg),
        .frame_sync(frame_sync),
        .triangle_sync(triangle_sync),
        .comparator_high(comparator_high),
        .pulse_polarity_select(pulse_polarity_select),
        .m(meter.source)
    );

    // run control and waveform timing
    phase_count_t phases;
    run_state_t state_reg, state_next;
    logic ctrl_en_reg, ctrl_en_next;
    logic [CNT_W-1:0] half_reg, half_next, width_reg, width_next, delay_reg, delay_next;
    logic [CNT_W-1:0] pos_reg, pos_next;

    assign phases = phase_count_of(lamp_count_bit_low, lamp_count_bit_high); // RULE8

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (ctrl_en_reg && lamp_status_line && level_in_range) state_next = ST_ARM; // RULE12
            end
            ST_ARM: begin
                if (!ctrl_en_reg || !lamp_status_line) state_next = ST_IDLE;
                else if (meter.upd) state_next = ST_RUN;
            end
            ST_RUN: begin
                if (!ctrl_en_reg || !lamp_status_line) state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
        half_next = half_reg;
        width_next = width_reg;
        delay_next = delay_reg;
        pos_next = pos_reg;
        if (meter.upd) begin
            half_next = meter.period >> 1; // RULE5
            width_next = meter.width >> 1; // RULE1
            delay_next = CNT_W'((meter.period >> 1) / phases); // RULE7
            pos_next = '0; // RULE3 RULE4
        end else if (tick_reg) begin
            if (pos_reg + 1'b1 >= half_reg) pos_next = '0;
            else pos_next = pos_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            half_reg <= '0;
            width_reg <= '0;
            delay_reg <= '0;
            pos_reg <= '0;
        end else begin
            state_reg <= state_next;
            half_reg <= half_next;
            width_reg <= width_next;
            delay_reg <= delay_next;
            pos_reg <= pos_next;
        end
    end

    // per-output phase compare
    logic [NCH-1:0] out_reg, out_next, oe_reg, oe_next;

    function automatic logic [CNT_W-1:0] lag_of(input logic [CNT_W-1:0] pos, input logic [CNT_W-1:0] off,
                                                input logic [CNT_W-1:0] half);
        if (pos >= off) lag_of = pos - off;
        else lag_of = pos + half - off;
    endfunction : lag_of

    always_comb begin
        logic [CNT_W-1:0] off;
        off = '0;
        for (int k = 0; k < NCH; k++) begin
            out_next[k] = (state_reg == ST_RUN) && (lag_of(pos_reg, off, half_reg) < width_reg); // RULE6
            oe_next[k] = (4'(k) < phases); // RULE13 RULE9
            off = off + delay_reg; // RULE7 RULE13
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            out_reg <= '0;
            oe_reg <= '0;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign dimming_outputs = out_reg;
    assign dimming_outputs_oe = oe_reg;

    // register port
    logic [31:0] rdata_reg, rdata_next;

    always_comb begin
        ctrl_en_next = ctrl_en_reg;
        if (reg_wr && reg_addr == `PWM_REG_CTRL) ctrl_en_next = reg_wdata[`PWM_CTRL_ENABLE_BIT];
        rdata_next = '0;
        if (reg_rd) begin
            case (reg_addr)
                `PWM_REG_CTRL: rdata_next[`PWM_CTRL_ENABLE_BIT] = ctrl_en_reg;
                `PWM_REG_STATUS: begin
                    rdata_next[`PWM_STATUS_RUN_BIT] = (state_reg == ST_RUN);
                    rdata_next[`PWM_STATUS_EXT_BIT] = meter.ext_present;
                    rdata_next[`PWM_STATUS_PHASE_LSB +: 4] = phases;
                end
                `PWM_REG_PERIOD: rdata_next[CNT_W-1:0] = meter.period;
                `PWM_REG_WIDTH: rdata_next[CNT_W-1:0] = meter.width;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_en_reg <= `PWM_CTRL_RESET;
            rdata_reg <= '0;
        end else begin
            ctrl_en_reg <= ctrl_en_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_tick_spacing;
        tick_reg |-> ##TICK_GAP tick_reg;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("time base not periodic"); // RULE10

    property p_twelve_phases;
        lamp_count_bit_low && lamp_count_bit_high |=> dimming_outputs_oe == 12'hfff;
    endproperty
    a_twelve_phases: assert property (p_twelve_phases) else $error("code 11 not twelve outputs"); // RULE8

    property p_six_float;
        !lamp_count_bit_low && !lamp_count_bit_high |=> dimming_outputs_oe == 12'h03f;
    endproperty
    a_six_float: assert property (p_six_float) else $error("unused outputs not floating"); // RULE13

    sequence s_not_ready;
        !lamp_status_line || !level_in_range;
    endsequence
    property p_start_gate;
        ((state_reg == ST_IDLE) and s_not_ready) |=> state_reg == ST_IDLE ##1 dimming_outputs == '0;
    endproperty
    a_start_gate: assert property (p_start_gate) else $error("started without status and range"); // RULE12

    property p_double_rate;
        meter.upd |=> half_reg == ($past(meter.period) >> 1);
    endproperty
    a_double_rate: assert property (p_double_rate) else $error("output period not half source"); // RULE5

    property p_phase_delay;
        meter.upd |=> delay_reg == CNT_W'(($past(meter.period) >> 1) / $past(phases));
    endproperty
    a_phase_delay: assert property (p_phase_delay) else $error("phase delay wrong"); // RULE7

    property p_resync;
        meter.upd |=> pos_reg == '0;
    endproperty
    a_resync: assert property (p_resync) else $error("phase counter not restarted"); // RULE3

    property p_first_leads;
        state_reg == ST_RUN && pos_reg == '0 && width_reg != '0 && delay_reg != '0 |=> dimming_outputs[0];
    endproperty
    a_first_leads: assert property (p_first_leads) else $error("output 0 not high at phase start"); // RULE6

    property p_ten_phases;
        lamp_count_bit_low && !lamp_count_bit_high |=> dimming_outputs_oe == 12'h3ff;
    endproperty
    a_ten_phases: assert property (p_ten_phases) else $error("code 10 not ten outputs"); // RULE8

    property p_eight_phases;
        !lamp_count_bit_low && lamp_count_bit_high |=> dimming_outputs_oe == 12'h0ff;
    endproperty
    a_eight_phases: assert property (p_eight_phases) else $error("code 01 not eight outputs"); // RULE8

    property p_idle_quiet;
        state_reg != ST_RUN |=> dimming_outputs == '0;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pulses while not running"); // RULE12

    property p_width_load;
        meter.upd |=> width_reg == ($past(meter.width) >> 1);
    endproperty
    a_width_load: assert property (p_width_load) else $error("pulse width not taken from measure"); // RULE1

    property p_pos_bound;
        state_reg == ST_RUN && half_reg != '0 |-> pos_reg < half_reg;
    endproperty
    a_pos_bound: assert property (p_pos_bound) else $error("phase counter beyond half period"); // RULE5

    property p_phase_wrap;
        tick_reg && !meter.upd && pos_reg + 1'b1 >= half_reg |=> pos_reg == '0;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase counter did not wrap"); // RULE5

    // a running set that loses enable or lamp status goes quiet two cycles later
    sequence s_run_dropped;
        state_reg == ST_RUN && (!ctrl_en_reg || !lamp_status_line);
    endsequence
    property p_stop_on_drop;
        s_run_dropped |=> state_reg == ST_IDLE ##1 dimming_outputs == '0;
    endproperty
    a_stop_on_drop: assert property (p_stop_on_drop) else $error("outputs kept after stop"); // RULE12

    property p_arm_waits;
        state_reg == ST_ARM && !meter.upd && ctrl_en_reg && lamp_status_line |=> state_reg == ST_ARM;
    endproperty
    a_arm_waits: assert property (p_arm_waits) else $error("started before a source edge"); // RULE4
endmodule : phase_shifted_dimming_pwm

`default_nettype wire

// *** core/dimming_pwm_defines.svh ***
/*
 * Constants for the phase-shifted dimming generator: timing counts,
 * register offsets, field positions and reset values.
 * Assumes nothing; holds definitions only.
 */
`ifndef DIMMING_PWM_DEFINES_SVH
`define DIMMING_PWM_DEFINES_SVH

// system clock and resonator time base
`define PWM_SYS_CLK_HZ 200000000
`define PWM_RESONATOR_HZ 4000000
`define PWM_TICK_DIV (`PWM_SYS_CLK_HZ / `PWM_RESONATOR_HZ)

// lowest usable sync frequency for each resonator
`define PWM_MIN_SYNC_HZ_4M00 61
`define PWM_MIN_SYNC_HZ_3M59 55
`define PWM_MIN_SYNC_HZ_3M00 46
// absence window: one period at the lowest usable sync, in resonator ticks
`define PWM_SYNC_TIMEOUT_TICKS (`PWM_RESONATOR_HZ / `PWM_MIN_SYNC_HZ_4M00)

// phase counts per lamp-count code
`define PWM_PHASES_00 4'h6
`define PWM_PHASES_01 4'h8
`define PWM_PHASES_10 4'ha
`define PWM_PHASES_11 4'hc
`define PWM_MAX_PHASES 12

// register map
`define PWM_REG_CTRL 4'h0
`define PWM_REG_STATUS 4'h4
`define PWM_REG_PERIOD 4'h8
`define PWM_REG_WIDTH 4'hc
`define PWM_CTRL_ENABLE_BIT 0
`define PWM_CTRL_RESET 1'h1
`define PWM_STATUS_RUN_BIT 0
`define PWM_STATUS_EXT_BIT 1
`define PWM_STATUS_PHASE_LSB 4

`endif

// *** core/dimming_pwm_pkg.sv ***
/*
 * Types shared by the dimming generator modules.
 * Assumes dimming_pwm_defines.svh is on the include path.
 */
`default_nettype none
`include "dimming_pwm_defines.svh"

package dimming_pwm_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARM = 2'b01,
        ST_RUN = 2'b10
    } run_state_t;

    typedef logic [3:0] phase_count_t;

    // low pin is the first code bit, high pin the second
    function automatic phase_count_t phase_count_of(input logic bit_low, input logic bit_high);
        case ({bit_low, bit_high})
            2'b00: phase_count_of = `PWM_PHASES_00;
            2'b01: phase_count_of = `PWM_PHASES_01;
            2'b10: phase_count_of = `PWM_PHASES_10;
            2'b11: phase_count_of = `PWM_PHASES_11;
            default: phase_count_of = `PWM_PHASES_00;
        endcase
    endfunction : phase_count_of

endpackage : dimming_pwm_pkg

`default_nettype wire

// *** core/sync_meter_if.sv ***
/*
 * Carries the measured sync period and pulse width from the meter to
 * the generator. Assumes both ends run on clk_sys.
 */
`default_nettype none

interface sync_meter_if #(parameter int CNT_W = 17);
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] width;
    logic upd;
    logic ext_present;
    modport source (output period, output width, output upd, output ext_present);
    modport sink (input period, input width, input upd, input ext_present);
endinterface : sync_meter_if

`default_nettype wire

// *** core/sync_period_meter.sv ***
/*
 * Picks the synchronising source and measures its period and the
 * selected comparator pulse width in resonator ticks.
 * Assumes all inputs synchronous to clk_sys and tick one cycle long.
 */
`default_nettype none
`include "dimming_pwm_defines.svh"

module sync_period_meter #(
    parameter int CNT_W = 17,
    parameter int TIMEOUT = `PWM_SYNC_TIMEOUT_TICKS
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic tick,
    input wire logic frame_sync,
    input wire logic triangle_sync,
    input wire logic comparator_high,
    input wire logic pulse_polarity_select,
    sync_meter_if.source m
);
    import dimming_pwm_pkg::*;

    initial begin
        if (TIMEOUT < 1 || TIMEOUT > (2 ** CNT_W) - 1) $error("TIMEOUT does not fit CNT_W");
    end

    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(TIMEOUT - 1);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    logic fs_prev_reg, fs_prev_next, tri_prev_reg, tri_prev_next;
    logic present_reg, present_next, upd_reg, upd_next;
    logic [CNT_W-1:0] gap_reg, gap_next, cnt_reg, cnt_next, acc_reg, acc_next;
    logic [CNT_W-1:0] period_reg, period_next, width_reg, width_next;
    logic ext_rise, tri_rise, src_edge, active;

    always_comb begin
        ext_rise = frame_sync & ~fs_prev_reg;
        tri_rise = triangle_sync & ~tri_prev_reg;
        src_edge = present_reg ? ext_rise : tri_rise; // RULE3 RULE4
        active = pulse_polarity_select ? comparator_high : ~comparator_high; // RULE2
        fs_prev_next = frame_sync;
        tri_prev_next = triangle_sync;
        present_next = present_reg;
        gap_next = gap_reg;
        if (ext_rise) begin
            present_next = 1'b1;
            gap_next = '0;
        end else if (tick && gap_reg != CNT_MAX) begin
            gap_next = gap_reg + 1'b1;
            if (gap_reg == LIMIT) present_next = 1'b0; // RULE14
        end
        cnt_next = cnt_reg;
        acc_next = acc_reg;
        period_next = period_reg;
        width_next = width_reg;
        upd_next = 1'b0;
        if (src_edge) begin
            period_next = cnt_reg;
            width_next = acc_reg; // RULE1
            upd_next = 1'b1;
            cnt_next = '0;
            acc_next = '0;
        end else if (tick && cnt_reg != CNT_MAX) begin
            cnt_next = cnt_reg + 1'b1;
            if (active) acc_next = acc_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fs_prev_reg <= 1'b0;
            tri_prev_reg <= 1'b0;
            present_reg <= 1'b0;
            upd_reg <= 1'b0;
            gap_reg <= '0;
            cnt_reg <= '0;
            acc_reg <= '0;
            period_reg <= '0;
            width_reg <= '0;
        end else begin
            fs_prev_reg <= fs_prev_next;
            tri_prev_reg <= tri_prev_next;
            present_reg <= present_next;
            upd_reg <= upd_next;
            gap_reg <= gap_next;
            cnt_reg <= cnt_next;
            acc_reg <= acc_next;
            period_reg <= period_next;
            width_reg <= width_next;
        end
    end

    assign m.period = period_reg;
    assign m.width = width_reg;
    assign m.upd = upd_reg;
    assign m.ext_present = present_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    property p_lock_external;
        present_reg && ext_rise |=> upd_reg;
    endproperty
    a_lock_external: assert property (p_lock_external) else $error("external edge did not resync"); // RULE3

    property p_lock_internal;
        !present_reg && tri_rise |=> upd_reg && period_reg == $past(cnt_reg);
    endproperty
    a_lock_internal: assert property (p_lock_internal) else $error("triangle edge did not resync"); // RULE4

    property p_sync_absent;
        tick && !ext_rise && gap_reg == LIMIT |=> !present_reg;
    endproperty
    a_sync_absent: assert property (p_sync_absent) else $error("sync timeout missed"); // RULE14

    property p_polarity_width;
        src_edge |=> width_reg <= period_reg;
    endproperty
    a_polarity_width: assert property (p_polarity_width) else $error("width exceeds period"); // RULE2
endmodule : sync_period_meter

`default_nettype wire

// *** testbench/lamp_controller_model.sv ***
/*
 * Far-side model: twelve per-lamp power controllers that watch their
 * dimming pins and log the last rise time, high time and period of each.
 * Assumes clk_sys drives the logging and meas_clr is a one-cycle pulse.
 */
`default_nettype none

module lamp_controller_model (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic meas_clr,
    input wire logic [11:0] dimming_outputs,
    input wire logic [11:0] dimming_outputs_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [11:0] lamp_in;
    logic [11:0] prev;
    int cyc;
    int rise_at [12];
    int hi_len [12];
    int per_len [12];

    // controller inputs carry pull-downs, so an undriven pin reads low
    assign lamp_in = dimming_outputs & dimming_outputs_oe;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cyc = 0;
            prev = 12'h000;
        end else begin
            cyc = cyc + 1;
            for (int k = 0; k < 12; k++) begin
                if (meas_clr) begin
                    rise_at[k] = 0;
                    hi_len[k] = 0;
                    per_len[k] = 0;
                end else if (lamp_in[k] && !prev[k]) begin
                    per_len[k] = cyc - rise_at[k];
                    rise_at[k] = cyc;
                end else if (!lamp_in[k] && prev[k]) begin
                    hi_len[k] = cyc - rise_at[k];
                end
            end
            prev = lamp_in;
        end
    end

endmodule : lamp_controller_model

`default_nettype wire

// *** testbench/phase_shifted_dimming_pwm_tb_top.sv ***
/*
 * Self-checking bench for the phase-shifted dimming generator.
 * Assumes a 200 MHz clk_sys and a 4 MHz tick of 50 clocks in the design.
 */
`default_nettype none

module phase_shifted_dimming_pwm_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICK = 50;
    localparam int TRI = 40;
    localparam int TMO = 120;

    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic frame_sync = 1'b0, triangle_sync = 1'b0, comparator_high = 1'b0;
    logic level_in_range = 1'b0, pulse_polarity_select = 1'b1, lamp_status_line = 1'b0;
    logic lamp_count_bit_low = 1'b0, lamp_count_bit_high = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, meas_clr = 1'b0, ext_on = 1'b0;
    logic [31:0] reg_rdata;
    logic [11:0] dimming_outputs, dimming_outputs_oe;
    logic [31:0] lfsr = 32'hbb79efbc;
    int error_cnt = 0, check_count = 0, cnt = 0, comp_hi = 20;

    always #2.5 clk_sys = ~clk_sys;

    // triangle marker, comparator and frame sync on the tick grid
    always @(posedge clk_sys) begin
        cnt <= (cnt == 2 * TRI * TICK - 1) ? 0 : cnt + 1;
        triangle_sync <= (cnt % (TRI * TICK)) < TICK;
        comparator_high <= (cnt % (TRI * TICK)) < comp_hi * TICK;
        frame_sync <= ext_on && cnt < TICK;
    end

    phase_shifted_dimming_pwm #(.SYNC_TIMEOUT_TICKS(TMO)) i_phase_shifted_dimming_pwm (
        .clk_sys(clk_sys), .resetn(resetn), .frame_sync(frame_sync), .triangle_sync(triangle_sync),
        .comparator_high(comparator_high), .level_in_range(level_in_range),
        .pulse_polarity_select(pulse_polarity_select), .lamp_count_bit_low(lamp_count_bit_low),
        .lamp_count_bit_high(lamp_count_bit_high), .lamp_status_line(lamp_status_line),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .dimming_outputs(dimming_outputs), .dimming_outputs_oe(dimming_outputs_oe)
    );

    lamp_controller_model i_lamp_controller_model (
        .clk_sys(clk_sys), .resetn(resetn), .meas_clr(meas_clr),
        .dimming_outputs(dimming_outputs), .dimming_outputs_oe(dimming_outputs_oe)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [3:0] phases_of(input logic [1:0] code);
        return 4'h6 + {1'b0, code, 1'b0};
    endfunction : phases_of

    task automatic conclude();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // measured times are quantised to the tick, so allow a little over one
    task automatic near(input string name, input int exp, input int got);
        check_count++;
        if (got < exp - 60 || got > exp + 60) begin
            error_cnt++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask : near

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
        @(posedge clk_sys);
    endtask : reg_check

    task automatic settle(input int periods);
        meas_clr <= 1'b1;
        @(posedge clk_sys);
        meas_clr <= 1'b0;
        repeat (periods * TRI * TICK) @(posedge clk_sys);
    endtask : settle

    task automatic check_set(input int src, input logic ext);
        int ph;
        int act;
        int half;
        #1;
        ph = phases_of({lamp_count_bit_low, lamp_count_bit_high});
        act = pulse_polarity_select ? comp_hi : TRI - comp_hi;
        half = src * TICK / 2;
        for (int k = 0; k < ph; k++) begin
            near("width", act * src * TICK / (2 * TRI), i_lamp_controller_model.hi_len[k]);
            near("period", half, i_lamp_controller_model.per_len[k]);
            if (k > 0) begin
                near("delay", half / ph, (i_lamp_controller_model.rise_at[k]
                    - i_lamp_controller_model.rise_at[k - 1] + half) % half);
            end
        end
        chk("oe", (32'h1 << ph) - 32'h1, {20'h0, dimming_outputs_oe});
        reg_check(4'h4, {24'h0, ph[3:0], 2'b00, ext, 1'b1});
    endtask : check_set

    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        reg_check(4'h0, 32'h1);
        reg_check(4'h4, 32'h60);
        reg_check(4'h2, 32'h0);
        reg_write(4'h4, 32'hffff_ffff);
        reg_check(4'h4, 32'h60);
        level_in_range <= 1'b1;
        settle(3);
        chk("pulses without status", 32'h0, 32'(i_lamp_controller_model.rise_at[0]));
        lamp_status_line <= 1'b1;
        level_in_range <= 1'b0;
        settle(3);
        chk("pulses out of range", 32'h0, 32'(i_lamp_controller_model.rise_at[0]));
        pulse_polarity_select <= 1'b0;
        comp_hi <= 10;
        level_in_range <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (i > 0) begin
                lfsr = lfsr_next(lfsr);
                comp_hi <= 8 + lfsr[7:0] % 25;
                pulse_polarity_select <= lfsr[8];
            end
            {lamp_count_bit_low, lamp_count_bit_high} <= 2'(i);
            settle(4);
            check_set(TRI, 1'b0);
        end
        ext_on <= 1'b1;
        settle(8);
        check_set(2 * TRI, 1'b1);
        ext_on <= 1'b0;
        repeat (TMO * TICK) @(posedge clk_sys);
        settle(4);
        check_set(TRI, 1'b0);
        reg_write(4'h0, 32'h0);
        repeat (4) @(posedge clk_sys);
        chk("disabled outputs", 32'h0, {20'h0, dimming_outputs});
        reg_check(4'h0, 32'h0);
        conclude();
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        error_cnt++;
        $display("ERROR watchdog expected done seen timeout");
        conclude();
    end

endmodule : phase_shifted_dimming_pwm_tb_top

`default_nettype wire
